// ===== common/acc_consts.svh
// timing counts and field codes for the converter control block
// assumes inclusion by bare name from package and design files
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_CLK_MHZ 250
`define ACC_CONV_NS 1000
`define ACC_CONV_CYC ((`ACC_CONV_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_CONV_RAC_NS 1200
`define ACC_CONV_RAC_CYC ((`ACC_CONV_RAC_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_RANGE_U5 2'h0
`define ACC_RANGE_U10 2'h1
`define ACC_RANGE_B5 2'h2
`define ACC_RANGE_B10 2'h3
`define ACC_CFG_RESET 8'h00
`define ACC_CFG_SPAN_BIT 0
`define ACC_CFG_SIGNED_BIT 1
`endif

// ===== common/acc_pkg.sv
// types shared by the converter control block
// assumes acc_consts.svh on the include path
package acc_pkg;
`include "acc_consts.svh"
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_CONV = 2'b01,
      ACC_LOAD = 2'b11
   } acc_state_t;
   typedef struct packed {
      logic signed_sel;
      logic span_sel;
   } acc_range_pins_t;
   typedef struct packed {
      logic serial_parallel_select;
      logic clock_source_select;
      logic read_during_convert_select;
      logic config_source_select;
   } acc_mode_t;
endpackage : acc_pkg

// ===== src/acc_control.sv
// control logic of a successive-approximation converter facing a host
// assumes pins arrive asynchronously and result data comes from the core
//
// Summary of operation
// R1 - busy rises at conversion start, falls after result loaded to shift register
// R2 - busy falling edge outside reset marks a fresh result for the host unless a read error pulses with it
// R3 - serial master read-after-convert uses a different busy duration
// R4 - signed and span selects decode into four input ranges
// R5 - result outputs driven only while chip select and read both low
// R6 - slave serial clock accepted only while chip select low
// R7 - reset high aborts any conversion without a result
// R8 - reset falling edge zeros result outputs and config register
// R9 - power-down lets current conversion finish then refuses new starts
// R10 - host interface stays alive during power-down
// R11 - start falling edge puts sampler in hold and begins conversion
// R12 - unfinished slave read at conversion end drops data, pulses read error
// R13 - software config source in serial mode takes range from config register
// R14 - start edges while busy are ignored
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_control
   import acc_pkg::*;
#(
   parameter int DATA_W = 14,
   parameter int CONV_CYC = `ACC_CONV_CYC,
   parameter int CONV_RAC_CYC = `ACC_CONV_RAC_CYC
) (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // host pins
   input wire logic convert_start_n_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic power_down_request_in,
   input wire logic ext_data_clk_in,
   input wire logic read_done_in,
   input wire acc_range_pins_t range_pins_in,
   input wire acc_mode_t mode_in,
   // software configuration register contents
   input wire logic [7:0] sw_config_in,
   input wire logic sw_config_we_in,
   // converter core result
   input wire logic [DATA_W-1:0] core_result_in,
   // outputs
   output logic busy_out,
   output logic hold_out,
   output logic low_power_out,
   output logic [1:0] range_out,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_out,
   output logic data_clk_gated_out,
   output logic read_error_flag_out,
   output logic [7:0] config_reg_out
);

   localparam int CNT_W = $clog2(CONV_RAC_CYC + CONV_CYC + 1);

   function automatic logic [1:0] range_decode(input logic signed_sel, input logic span_sel);
      range_decode = {signed_sel, span_sel}; // see R4
   endfunction : range_decode

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [5:0] s1_reg, s2_reg;
   logic [5:0] s1_next, s2_next;
   always_comb begin
      s1_next = {ext_data_clk_in, read_done_in, power_down_request_in,
                 rd_n_in, cs_n_in, convert_start_n_in};
      s2_next = s1_reg;
   end
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s1_reg <= 6'h3f;
         s2_reg <= 6'h3f;
      end else if (clk_en_in) begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end
   logic cnv_n_s, cs_n_s, rd_n_s, pd_s, rdone_s, eclk_s;
   assign cnv_n_s = s2_reg[0];
   assign cs_n_s = s2_reg[1];
   assign rd_n_s = s2_reg[2];
   assign pd_s = s2_reg[3];
   assign rdone_s = s2_reg[4];
   assign eclk_s = s2_reg[5];

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   acc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic cnv_prev_reg, cnv_prev_next;
   logic rst_prev_reg, rst_prev_next;
   logic [DATA_W-1:0] data_reg, data_next;
   logic [7:0] cfg_reg, cfg_next;
   logic rd_active_reg, rd_active_next;
   logic rderr_reg, rderr_next;
   logic start_edge, master_rac, slave_mode;

   assign start_edge = cnv_prev_reg & ~cnv_n_s; // see R11
   assign master_rac = mode_in.serial_parallel_select & ~mode_in.clock_source_select
                       & ~mode_in.read_during_convert_select;
   assign slave_mode = mode_in.serial_parallel_select & mode_in.clock_source_select;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cnv_prev_next = cnv_n_s;
      rst_prev_next = 1'b0;
      data_next = data_reg;
      cfg_next = cfg_reg;
      rd_active_next = rd_active_reg;
      rderr_next = 1'b0;
      if (sw_config_we_in) begin
         cfg_next = sw_config_in;
      end
      if (slave_mode && !cs_n_s && !rd_n_s) begin
         rd_active_next = 1'b1;
      end
      if (rdone_s) begin
         rd_active_next = 1'b0;
      end
      case (state_reg)
         ACC_IDLE: begin
            // see R9 see R14
            if (start_edge && !pd_s) begin
               state_next = ACC_CONV;
               cnt_next = master_rac ? CNT_W'(CONV_RAC_CYC - 1)
                                     : CNT_W'(CONV_CYC - 1); // see R3
            end
         end
         ACC_CONV: begin
            if (cnt_reg == '0) begin
               state_next = ACC_LOAD;
            end else begin
               cnt_next = cnt_reg - CNT_W'(1);
            end
         end
         ACC_LOAD: begin
            state_next = ACC_IDLE; // see R1
            if (slave_mode && rd_active_reg) begin
               rderr_next = 1'b1; // see R12
               rd_active_next = 1'b0;
            end else begin
               data_next = core_result_in;
            end
         end
         default: begin
            state_next = ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         // see R7
         state_reg <= ACC_IDLE;
         cnt_reg <= '0;
         cnv_prev_reg <= 1'b1;
         rst_prev_reg <= 1'b1;
         rd_active_reg <= 1'b0;
         rderr_reg <= 1'b0;
         data_reg <= data_reg;
         cfg_reg <= cfg_reg;
      end else if (clk_en_in) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cnv_prev_reg <= cnv_prev_next;
         rst_prev_reg <= rst_prev_next;
         rd_active_reg <= rd_active_next;
         rderr_reg <= rderr_next;
         // see R8
         data_reg <= rst_prev_reg ? '0 : data_next;
         cfg_reg <= rst_prev_reg ? `ACC_CFG_RESET : cfg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   logic [1:0] range_sel;
   always_comb begin
      // see R13
      if (mode_in.serial_parallel_select && !mode_in.config_source_select) begin
         range_sel = range_decode(cfg_reg[`ACC_CFG_SIGNED_BIT], cfg_reg[`ACC_CFG_SPAN_BIT]);
      end else begin
         range_sel = range_decode(range_pins_in.signed_sel, range_pins_in.span_sel);
      end
   end

   assign busy_out = (state_reg != ACC_IDLE); // see R1 see R2
   assign hold_out = (state_reg != ACC_IDLE);
   assign low_power_out = pd_s & (state_reg == ACC_IDLE); // see R9
   assign range_out = range_sel;
   assign data_out = data_reg; // see R10
   assign data_oe_out = ~cs_n_s & ~rd_n_s; // see R5
   assign data_clk_gated_out = slave_mode & ~cs_n_s & eclk_s; // see R6
   assign read_error_flag_out = rderr_reg;
   assign config_reg_out = cfg_reg;

endmodule : acc_control

// ===== testbench/acc_control_chk.sv
// port assertions for acc_control
// assumes a bind into acc_control
`timescale 1ns/1ps
module acc_control_chk
   import acc_pkg::*;
#(parameter int DATA_W = 14, parameter int CONV_CYC = 4, parameter int CONV_RAC_CYC = 6) (
   input wire logic clk_in, reset_in, cs_n_in, rd_n_in, power_down_request_in,
   input wire logic ext_data_clk_in,
   input wire acc_range_pins_t range_pins_in,
   input wire acc_mode_t mode_in,
   input wire logic [DATA_W-1:0] core_result_in, data_out,
   input wire logic [7:0] config_reg_out,
   input wire logic [1:0] range_out,
   input wire logic busy_out, hold_out, low_power_out, data_oe_out, data_clk_gated_out,
   input wire logic read_error_flag_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire rac = mode_in.serial_parallel_select && !mode_in.clock_source_select
      && !mode_in.read_during_convert_select;
   wire sw = mode_in.serial_parallel_select && !mode_in.config_source_select;
   wire slv = mode_in.serial_parallel_select && mode_in.clock_source_select;
   logic [15:0] len_reg;
   always_ff @(posedge clk_in) len_reg <= busy_out ? len_reg + 16'h0001 : 16'h0000;
   sequence s_rd_steady; $stable({cs_n_in, rd_n_in}) [*3]; endsequence
   sequence s_pd_idle; (power_down_request_in && !busy_out) [*4]; endsequence
   a_hold_busy: assert property (hold_out == busy_out) else $error("hold");
   a_range_decode: assert property (range_out == (sw ? config_reg_out[1:0] : range_pins_in))
      else $error("range");
   a_busy_len: assert property ($fell(busy_out) |-> len_reg == (rac ? CONV_RAC_CYC + 1 :
      CONV_CYC + 1)) else $error("busy length");
   a_pd_refuse: assert property (s_pd_idle |=> !busy_out && low_power_out)
      else $error("power down");
   a_read_oe: assert property (s_rd_steady |-> data_oe_out == (!cs_n_in && !rd_n_in))
      else $error("output enable");
   a_clk_gate: assert property (cs_n_in [*3] |-> !data_clk_gated_out) else $error("gate");
   a_clk_pass: assert property ((slv && !cs_n_in) [*3] |->
      data_clk_gated_out == $past(ext_data_clk_in, 2)) else $error("clock pass");
   a_reset_clear: assert property ($fell(reset_in) |=> data_out == '0 && !busy_out
      && config_reg_out == 8'h00) else $error("reset");
   a_data_load: assert property ($fell(busy_out) |-> data_out == (read_error_flag_out ?
      $past(data_out) : $past(core_result_in))) else $error("load");
endmodule : acc_control_chk
bind acc_control acc_control_chk #(.DATA_W(DATA_W), .CONV_CYC(CONV_CYC),
   .CONV_RAC_CYC(CONV_RAC_CYC)) u_chk (.*);

// ===== testbench/acc_host_model.sv
// host model: reads each fresh result once busy falls
// assumes busy from the control block
`timescale 1ns/1ps
module acc_host_model (
   input wire logic clk_in, busy_in, slow_in,
   output logic cs_n_out, rd_n_out
);
   logic busy_reg = 1'b0;
   logic [3:0] cnt_reg = 4'h0;
   always_ff @(posedge clk_in) begin
      busy_reg <= busy_in;
      if (busy_reg && !busy_in) cnt_reg <= slow_in ? 4'h9 : 4'h3;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
   end
   assign cs_n_out = cnt_reg == 4'h0;
   assign rd_n_out = cs_n_out;
endmodule : acc_host_model

// ===== testbench/acc_control_tb.sv
// self-checking bench for acc_control
// assumes the bound checker and acc_host_model
`timescale 1ns/1ps
module acc_control_tb
   import acc_pkg::*;
;
   logic clk_in = 0, reset_in = 1, st_n = 1, pd = 0, done = 1, eclk = 0, we = 0, slow = 0;
   logic [7:0] cfg = 8'h00;
   logic [13:0] res = '0, last = '0, dout;
   acc_range_pins_t pins = '0;
   acc_mode_t mode = 4'h1;
   logic cs_n, rd_n, busy, lp, err, oe, busy_q = 0;
   logic [14:0] exp_q [$];
   logic [3:0] modes [5] = '{4'h1, 4'h9, 4'hb, 4'hd, 4'ha};
   int miscompares = 0, comparisons = 0, cyc = 0;
   acc_control #(.DATA_W(14), .CONV_CYC(4), .CONV_RAC_CYC(6)) DUT (.clk_in, .reset_in,
      .clk_en_in(1'b1), .convert_start_n_in(st_n), .cs_n_in(cs_n), .rd_n_in(rd_n),
      .power_down_request_in(pd), .ext_data_clk_in(eclk), .read_done_in(done),
      .range_pins_in(pins), .mode_in(mode), .sw_config_in(cfg), .sw_config_we_in(we),
      .core_result_in(res), .busy_out(busy), .hold_out(), .low_power_out(lp), .range_out(),
      .data_out(dout), .data_oe_out(oe), .data_clk_gated_out(), .read_error_flag_out(err),
      .config_reg_out());
   acc_host_model HOST (.clk_in, .busy_in(busy), .slow_in(slow), .cs_n_out(cs_n), .rd_n_out(rd_n));
   initial forever #2 clk_in = ~clk_in;
   task check(input string n, input logic [14:0] e, input logic [14:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task end_of_test;
      if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   always @(posedge clk_in) begin
      busy_q <= busy;
      cyc <= cyc + 1;
      eclk <= 1'($urandom);
      if (busy_q === 1'b1 && busy === 1'b0 && !reset_in)
         check("result", exp_q.size() ? exp_q.pop_front() : 'x, {err, dout});
      if (cyc == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic conv(input logic e, input logic twice, input logic p);
      logic [13:0] r;
      int i;
      r = 14'($urandom);
      @(posedge clk_in);
      st_n <= 1'b0;
      res <= r;
      pins <= 2'($urandom);
      slow <= 1'($urandom);
      exp_q.push_back(e ? {1'b1, last} : {1'b0, r});
      if (!e) last = r;
      repeat (2) @(posedge clk_in);
      st_n <= 1'b1;
      for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk_in);
      st_n <= !twice;
      pd <= p;
      for (i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk_in);
      st_n <= 1'b1;
      repeat (12) @(posedge clk_in);
   endtask : conv
   initial begin
      void'($urandom(8));
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      foreach (modes[k]) begin
         mode <= modes[k];
         cfg <= 8'($urandom);
         we <= 1'b1;
         @(posedge clk_in) we <= 1'b0;
         conv(0, 0, 0);
         conv(0, 1, 0);
      end
      mode <= 4'hd;
      done <= 1'b0;
      conv(0, 0, 0);
      conv(1, 0, 0);
      done <= 1'b1;
      conv(0, 1, 1);
      st_n <= 1'b0;
      repeat (10) @(posedge clk_in);
      check("power_down", 15'h0001, {busy, lp});
      st_n <= 1'b1;
      pd <= 1'b0;
      repeat (6) @(posedge clk_in) st_n <= 1'b0;
      repeat (4) @(posedge clk_in) reset_in <= 1'b1;
      st_n <= 1'b1;
      repeat (2) @(posedge clk_in) reset_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("reset", 15'h0000, {busy, dout});
      check("pending", 15'h0000, 15'(exp_q.size()));
      end_of_test();
   end
endmodule : acc_control_tb
